// File: verilog/rcs_render_regs.sv
`timescale 1ns/1ps
// Function
// R1: secondary clip rectangle is inclusive or exclusive by the mode flag.
// R2: pixels in an excluded region skip both color and aux writes.
// R3: rectangle includes left and top, excludes right and bottom.
// R4: software keeps top below bottom and left below right.
// R5: horizontal clip: right 11:0, left 27:16, enable bit 31.
// R6: vertical clip: top 11:0, bottom 27:16, mode bit 31.
// R7: each direct swap-pending write bumps the pending swap count at once.
// R8: swap-pending writes count only from direct access, not the queue.
// R9: left overlay address 23:0 taken at end of vertical retrace.
// R10: software aligns overlay addresses to 32 or 64 bit boundaries.
// R11: left overlay bit 31 marks even (1) or odd (0) field.
// R12: right overlay address 23:0 for stereo, taken at retrace end.
// R13: each completed swap shifts history bits 27:0 up into 31:4.
// R14: history bits 3:0 take vsyncs since last swap, capped at 0xf.
// R15: 24-bit counter counts processed triangles, not culled ones.
// R16: triangle counter clears at reset and on no-op bit 1 write.
// R17: setup bits 7:0 pick parameter groups; clear bits keep old values.
// R18: setup bit 16 picks strip (0) or fan (1).
// R19: setup bit 17 enables culling, bit 18 picks culling sign.
// R20: setup bit 19 stops alternating strip sign correction.
// R21: reserved bits read zero and ignore writes.
module rcs_render_regs
  import rcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic regQueued,
  input wire logic [3:0] regIndex,
  input wire logic [31:0] regWriteData,
  output logic [31:0] regReadData_reg,
  output logic regReadValid_reg,
  input wire logic nopWrite,
  input wire logic [31:0] nopWriteData,
  output logic swapPendingIncrement_reg,
  input wire logic swapDone,
  input wire logic vsyncPulse,
  input wire logic retraceEnd,
  output logic [23:0] overlayLeftAddr_reg,
  output logic overlayLeftEven_reg,
  output logic [23:0] overlayRightAddr_reg,
  input wire logic triBegin,
  input wire logic triProcessed,
  input wire logic triCulled,
  output logic [7:0] setupParamEnable,
  output logic setupFanMode,
  output logic setupCullEnable,
  output logic setupCullSign,
  input wire logic [31:0] primaryClipHorizontal,
  input wire logic [31:0] primaryClipVertical,
  input wire logic pixValid,
  input wire logic [11:0] pixX,
  input wire logic [11:0] pixY,
  output logic pixColorWrite,
  output logic pixAuxWrite
);

  logic rstMeta_reg;
  logic rstN;
  logic [31:0] clipHorizontal_reg;
  logic [31:0] clipVertical_reg;
  logic [31:0] overlayLeft_reg;
  logic [31:0] overlayRight_reg;
  logic [31:0] swapHistory_reg;
  logic [31:0] swapHistory_next;
  logic [3:0] vsyncCount_reg;
  logic [3:0] vsyncCount_next;
  logic [23:0] triCount_reg;
  logic [31:0] setupControl_reg;
  logic stripParity_reg;
  logic [31:0] readWord;
  logic directWrite;

  rcs_clip_if clipBus ();

  // ==========================================================
  // reset release through two flops
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstMeta_reg <= 1'b0;
      rstN <= 1'b0;
    end
    else
    begin
      rstMeta_reg <= 1'b1;
      rstN <= rstMeta_reg;
    end
  end

  // ==========================================================
  // write decode helper
  function automatic logic rcs_hit(input logic wr, input logic [3:0] idx,
                                   input logic [3:0] target);
    rcs_hit = wr && (idx == target);
  endfunction : rcs_hit

  assign directWrite = regWrite && !regQueued;

  // ==========================================================
  // clip registers
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      clipHorizontal_reg <= RESET_WORD;
      clipVertical_reg <= RESET_WORD;
    end
    else
    begin
      if (rcs_hit(regWrite, regIndex, IDX_CLIP_HORIZONTAL))
      begin
        clipHorizontal_reg <= regWriteData & MASK_CLIP; // see R5 R21
      end
      if (rcs_hit(regWrite, regIndex, IDX_CLIP_VERTICAL))
      begin
        clipVertical_reg <= regWriteData & MASK_CLIP; // see R6 R21
      end
    end
  end

  assign clipBus.clipHorizontal = clipHorizontal_reg;
  assign clipBus.clipVertical = clipVertical_reg;
  assign clipBus.primaryHorizontal = primaryClipHorizontal;
  assign clipBus.primaryVertical = primaryClipVertical;

  rcs_clip_check i_rcs_clip_check
  (
    .clk(clk),
    .rstN(rstN),
    .clipCfg(clipBus.check),
    .pixValid(pixValid),
    .pixX(pixX),
    .pixY(pixY),
    .pixColorWrite_reg(pixColorWrite),
    .pixAuxWrite_reg(pixAuxWrite)
  );

  // ==========================================================
  // swap pending port, direct access only
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      swapPendingIncrement_reg <= 1'b0;
    end
    else
    begin
      swapPendingIncrement_reg <= rcs_hit(directWrite, regIndex, IDX_SWAP_PENDING); // see R7 R8
    end
  end

  // ==========================================================
  // overlay start registers and retrace-end sampling
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      overlayLeft_reg <= RESET_WORD;
      overlayRight_reg <= RESET_WORD;
    end
    else
    begin
      if (rcs_hit(regWrite, regIndex, IDX_OVERLAY_LEFT))
      begin
        overlayLeft_reg <= regWriteData & MASK_OVERLAY_LEFT; // see R11 R21
      end
      if (rcs_hit(regWrite, regIndex, IDX_OVERLAY_RIGHT))
      begin
        overlayRight_reg <= regWriteData & MASK_OVERLAY_RIGHT; // see R12 R21
      end
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      overlayLeftAddr_reg <= '0;
      overlayLeftEven_reg <= 1'b0;
      overlayRightAddr_reg <= '0;
    end
    else if (retraceEnd)
    begin
      overlayLeftAddr_reg <= overlayLeft_reg[ADDR_W-1:0]; // see R9
      overlayLeftEven_reg <= overlayLeft_reg[OVL_FIELD_BIT]; // see R11
      overlayRightAddr_reg <= overlayRight_reg[ADDR_W-1:0]; // see R12
    end
  end

  // ==========================================================
  // vsync counting and swap history
  always_comb
  begin
    vsyncCount_next = vsyncCount_reg;
    if (vsyncPulse && (vsyncCount_reg != SLOT_SATURATE))
    begin
      vsyncCount_next = vsyncCount_reg + SLOT_ONE; // see R14
    end
    swapHistory_next = {swapHistory_reg[DATA_W-SLOT_W-1:0], vsyncCount_next}; // see R13 R14
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      vsyncCount_reg <= '0;
      swapHistory_reg <= RESET_WORD;
    end
    else if (swapDone)
    begin
      vsyncCount_reg <= '0;
      swapHistory_reg <= swapHistory_next; // see R13
    end
    else
    begin
      vsyncCount_reg <= vsyncCount_next;
    end
  end

  // ==========================================================
  // triangle counter
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      triCount_reg <= '0; // see R16
    end
    else if (nopWrite && nopWriteData[NOP_TRI_CLEAR_BIT])
    begin
      triCount_reg <= '0; // see R16
    end
    else if (triProcessed && !triCulled)
    begin
      triCount_reg <= triCount_reg + COUNT_ONE; // see R15
    end
  end

  // ==========================================================
  // setup control and strip sign alternation
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      setupControl_reg <= RESET_WORD;
    end
    else if (rcs_hit(regWrite, regIndex, IDX_SETUP_CONTROL))
    begin
      setupControl_reg <= regWriteData & MASK_SETUP; // see R17 R21
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      stripParity_reg <= 1'b0;
    end
    else if (triBegin)
    begin
      stripParity_reg <= 1'b0;
    end
    else if (triProcessed)
    begin
      stripParity_reg <= !stripParity_reg;
    end
  end

  assign setupParamEnable = setupControl_reg[PARAM_W-1:0]; // see R17
  assign setupFanMode = setupControl_reg[SETUP_FAN_BIT]; // see R18
  assign setupCullEnable = setupControl_reg[SETUP_CULL_BIT]; // see R19
  // odd strip triangles flip the sign unless fan or correction disabled
  assign setupCullSign = setupControl_reg[SETUP_SIGN_BIT] ^ (stripParity_reg
    && !setupControl_reg[SETUP_FAN_BIT] && !setupControl_reg[SETUP_PINGPONG_BIT]); // see R19 R20

  // ==========================================================
  // readback
  always_comb
  begin
    case (regIndex)
      IDX_CLIP_HORIZONTAL: readWord = clipHorizontal_reg;
      IDX_CLIP_VERTICAL: readWord = clipVertical_reg;
      IDX_OVERLAY_LEFT: readWord = overlayLeft_reg;
      IDX_OVERLAY_RIGHT: readWord = overlayRight_reg;
      IDX_SWAP_HISTORY: readWord = swapHistory_reg;
      IDX_TRI_COUNT: readWord = {8'h00, triCount_reg} & MASK_TRI_COUNT; // see R21
      IDX_SETUP_CONTROL: readWord = setupControl_reg;
      default: readWord = RESET_WORD; // see R21
    endcase
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      regReadData_reg <= RESET_WORD;
      regReadValid_reg <= 1'b0;
    end
    else
    begin
      regReadValid_reg <= regRead;
      if (regRead)
      begin
        regReadData_reg <= readWord;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rstN);

  a_swap_pend_pulse: assert property ( // see R7
    (regWrite && !regQueued && regIndex == IDX_SWAP_PENDING) |=> swapPendingIncrement_reg)
    else $error("swap pending write not counted");
  a_queued_swap_ignored: assert property ( // see R8
    (!(regWrite && !regQueued && regIndex == IDX_SWAP_PENDING)) |=> !swapPendingIncrement_reg)
    else $error("swap pending counted without direct write");
  a_overlay_left_hold: assert property ( // see R9 R11
    !retraceEnd |=> $stable(overlayLeftAddr_reg) && $stable(overlayLeftEven_reg))
    else $error("left overlay changed outside retrace end");
  a_overlay_sample: assert property ( // see R9 R12
    retraceEnd |=> overlayRightAddr_reg == $past(overlayRight_reg[23:0])
      && overlayLeftAddr_reg == $past(overlayLeft_reg[23:0]))
    else $error("overlay address not sampled at retrace end");
  a_history_shift: assert property ( // see R13
    swapDone |=> swapHistory_reg[31:4] == $past(swapHistory_reg[27:0]))
    else $error("swap history not shifted");
  a_history_saturate: assert property ( // see R14
    (swapDone && vsyncCount_reg == 4'hf) |=> swapHistory_reg[3:0] == 4'hf)
    else $error("swap history slot not saturated");
  a_tri_culled_skip: assert property ( // see R15
    (triCulled && !nopWrite) |=> $stable(triCount_reg))
    else $error("culled triangle was counted");
  a_tri_count_step: assert property ( // see R15
    (triProcessed && !triCulled && !nopWrite) |=> triCount_reg == $past(triCount_reg) + 24'h1)
    else $error("triangle count did not step");
  a_tri_clear: assert property ( // see R16
    (nopWrite && nopWriteData[1]) |=> triCount_reg == 24'h0)
    else $error("triangle count not cleared");
  a_pingpong_off: assert property ( // see R18 R20
    (setupControl_reg[19] || setupControl_reg[16]) |-> setupCullSign == setupControl_reg[18])
    else $error("sign alternated while disabled");
  a_reserved_zero: assert property ( // see R21
    regReadValid_reg && $past(regIndex) == IDX_SETUP_CONTROL |-> regReadData_reg[15:8] == 8'h00)
    else $error("reserved setup bits read nonzero");

  c_swap_twice: cover property (swapDone ##[1:20] swapDone);
  c_tri_counted: cover property (triProcessed && !triCulled ##2 triProcessed && !triCulled);
  c_retrace_latch: cover property (regWrite && regIndex == IDX_OVERLAY_LEFT ##[1:10] retraceEnd);
  c_queued_swap: cover property (regWrite && regQueued && regIndex == IDX_SWAP_PENDING);

endmodule : rcs_render_regs

// File: verilog/rcs_pkg.sv
// ==========================================================
// register indices, field layout and reset values
package rcs_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned COORD_W = 12;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned COUNT_W = 24;
  localparam int unsigned SLOT_W = 4;
  localparam int unsigned PARAM_W = 8;

  // register indices on the register port, word addressed
  localparam logic [3:0] IDX_CLIP_HORIZONTAL = 4'h0;
  localparam logic [3:0] IDX_CLIP_VERTICAL = 4'h1;
  localparam logic [3:0] IDX_SWAP_PENDING = 4'h2;
  localparam logic [3:0] IDX_OVERLAY_LEFT = 4'h3;
  localparam logic [3:0] IDX_OVERLAY_RIGHT = 4'h4;
  localparam logic [3:0] IDX_SWAP_HISTORY = 4'h5;
  localparam logic [3:0] IDX_TRI_COUNT = 4'h6;
  localparam logic [3:0] IDX_SETUP_CONTROL = 4'h7;

  // implemented bits of each register; everything else is reserved
  localparam logic [31:0] MASK_CLIP = 32'h8fff_0fff;
  localparam logic [31:0] MASK_OVERLAY_LEFT = 32'h80ff_ffff;
  localparam logic [31:0] MASK_OVERLAY_RIGHT = 32'h00ff_ffff;
  localparam logic [31:0] MASK_SETUP = 32'h000f_00ff;
  localparam logic [31:0] MASK_TRI_COUNT = 32'h00ff_ffff;

  // field positions
  localparam int unsigned CLIP_NEAR_LSB = 0;
  localparam int unsigned CLIP_FAR_LSB = 16;
  localparam int unsigned CLIP_FLAG_BIT = 31;
  localparam int unsigned OVL_FIELD_BIT = 31;
  localparam int unsigned SETUP_FAN_BIT = 16;
  localparam int unsigned SETUP_CULL_BIT = 17;
  localparam int unsigned SETUP_SIGN_BIT = 18;
  localparam int unsigned SETUP_PINGPONG_BIT = 19;
  localparam int unsigned NOP_TRI_CLEAR_BIT = 1;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [3:0] SLOT_SATURATE = 4'hf;
  localparam logic [3:0] SLOT_ONE = 4'h1;
  localparam logic [23:0] COUNT_ONE = 24'h00_0001;

endpackage : rcs_pkg

// File: verilog/rcs_clip_if.sv
`timescale 1ns/1ps
// ==========================================================
// clip rectangle settings from the register bank to the checker
interface rcs_clip_if;
  logic [31:0] clipHorizontal;
  logic [31:0] clipVertical;
  logic [31:0] primaryHorizontal;
  logic [31:0] primaryVertical;

  modport bank
  (
    output clipHorizontal,
    output clipVertical,
    output primaryHorizontal,
    output primaryVertical
  );

  modport check
  (
    input clipHorizontal,
    input clipVertical,
    input primaryHorizontal,
    input primaryVertical
  );
endinterface : rcs_clip_if

// File: verilog/rcs_clip_check.sv
`timescale 1ns/1ps
// ==========================================================
// per-pixel write gate from the primary and secondary rectangles
module rcs_clip_check
  import rcs_pkg::*;
(
  input wire logic clk,
  input wire logic rstN,
  rcs_clip_if.check clipCfg,
  input wire logic pixValid,
  input wire logic [11:0] pixX,
  input wire logic [11:0] pixY,
  output logic pixColorWrite_reg,
  output logic pixAuxWrite_reg
);

  logic allowNext;
  logic insidePrimary;
  logic insideSecondary;

  // ========================================================
  // rectangle test: near edges included, far edges excluded
  function automatic logic rcs_inside(input logic [31:0] h, input logic [31:0] v,
                                      input logic [11:0] x, input logic [11:0] y);
    logic [11:0] minX;
    logic [11:0] maxX;
    logic [11:0] minY;
    logic [11:0] maxY;
    minX = h[CLIP_FAR_LSB +: COORD_W];
    maxX = h[CLIP_NEAR_LSB +: COORD_W];
    minY = v[CLIP_NEAR_LSB +: COORD_W];
    maxY = v[CLIP_FAR_LSB +: COORD_W];
    rcs_inside = (x >= minX) && (x < maxX) && (y >= minY) && (y < maxY); // see R3 R5 R6
  endfunction : rcs_inside

  assign insidePrimary = rcs_inside(clipCfg.primaryHorizontal, clipCfg.primaryVertical, pixX, pixY);
  assign insideSecondary = rcs_inside(clipCfg.clipHorizontal, clipCfg.clipVertical, pixX, pixY);

  always_comb
  begin
    allowNext = pixValid && insidePrimary;
    if (clipCfg.clipHorizontal[CLIP_FLAG_BIT])
    begin
      // mode flag: 0 draws only inside, 1 forbids inside
      if (clipCfg.clipVertical[CLIP_FLAG_BIT])
      begin
        allowNext = allowNext && !insideSecondary; // see R1
      end
      else
      begin
        allowNext = allowNext && insideSecondary; // see R1
      end
    end
  end

  // ========================================================
  // both buffers share one gate
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pixColorWrite_reg <= 1'b0;
      pixAuxWrite_reg <= 1'b0;
    end
    else
    begin
      pixColorWrite_reg <= allowNext; // see R2
      pixAuxWrite_reg <= allowNext; // see R2
    end
  end

  // ========================================================
  // checks
  a_excluded_no_write: assert property (@(posedge clk) disable iff (!rstN) // see R2
    (clipCfg.clipHorizontal[31] && clipCfg.clipVertical[31] && insideSecondary)
    |=> !pixColorWrite_reg && !pixAuxWrite_reg)
    else $error("pixel written inside excluded rectangle");
  a_buffers_agree: assert property (@(posedge clk) disable iff (!rstN) // see R2
    pixColorWrite_reg == pixAuxWrite_reg)
    else $error("color and aux write gates differ");
  a_far_edge_out: assert property (@(posedge clk) disable iff (!rstN) // see R3
    (pixX == clipCfg.clipHorizontal[11:0]) |-> !insideSecondary)
    else $error("right edge treated as inside");
  a_inclusive_gate: assert property (@(posedge clk) disable iff (!rstN) // see R1
    (pixValid && clipCfg.clipHorizontal[31] && !clipCfg.clipVertical[31] && !insideSecondary)
    |=> !pixColorWrite_reg)
    else $error("pixel written outside inclusive rectangle");
  c_exclusive_block: cover property (@(posedge clk) disable iff (!rstN)
    pixValid && insidePrimary && clipCfg.clipHorizontal[31] && clipCfg.clipVertical[31]
    && insideSecondary);

endmodule : rcs_clip_check

// File: dv/tb_rcs_render_regs.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the render register bank
module tb_rcs_render_regs;
  import rcs_pkg::*;

  logic clk;
  logic reset_n;
  logic regWrite;
  logic regRead;
  logic regQueued;
  logic [3:0] regIndex;
  logic [31:0] regWriteData;
  logic [31:0] regReadData_reg;
  logic regReadValid_reg;
  logic nopWrite;
  logic [31:0] nopWriteData;
  logic swapPendingIncrement_reg;
  logic swapDone;
  logic vsyncPulse;
  logic retraceEnd;
  logic [23:0] overlayLeftAddr_reg;
  logic overlayLeftEven_reg;
  logic [23:0] overlayRightAddr_reg;
  logic triBegin;
  logic triProcessed;
  logic triCulled;
  logic [7:0] setupParamEnable;
  logic setupFanMode;
  logic setupCullEnable;
  logic setupCullSign;
  logic [31:0] primaryClipHorizontal;
  logic [31:0] primaryClipVertical;
  logic pixValid;
  logic [11:0] pixX;
  logic [11:0] pixY;
  logic pixColorWrite;
  logic pixAuxWrite;
  int error_cnt;
  int n_compared;
  logic [31:0] hist;
  logic inRect;
  logic [11:0] px [5];
  logic [11:0] py [5];
  int cnt [4];

  rcs_render_regs i_rcs_render_regs
  (
    .clk(clk), .reset_n(reset_n), .regWrite(regWrite), .regRead(regRead),
    .regQueued(regQueued), .regIndex(regIndex), .regWriteData(regWriteData),
    .regReadData_reg(regReadData_reg), .regReadValid_reg(regReadValid_reg),
    .nopWrite(nopWrite), .nopWriteData(nopWriteData),
    .swapPendingIncrement_reg(swapPendingIncrement_reg), .swapDone(swapDone),
    .vsyncPulse(vsyncPulse), .retraceEnd(retraceEnd),
    .overlayLeftAddr_reg(overlayLeftAddr_reg), .overlayLeftEven_reg(overlayLeftEven_reg),
    .overlayRightAddr_reg(overlayRightAddr_reg), .triBegin(triBegin),
    .triProcessed(triProcessed), .triCulled(triCulled),
    .setupParamEnable(setupParamEnable), .setupFanMode(setupFanMode),
    .setupCullEnable(setupCullEnable), .setupCullSign(setupCullSign),
    .primaryClipHorizontal(primaryClipHorizontal), .primaryClipVertical(primaryClipVertical),
    .pixValid(pixValid), .pixX(pixX), .pixY(pixY),
    .pixColorWrite(pixColorWrite), .pixAuxWrite(pixAuxWrite)
  );

  // ==========================================================
  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end

  // ==========================================================
  // access tasks
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    tick();
    regWrite = 1'b1;
    regIndex = idx;
    regWriteData = d;
    tick();
    regWrite = 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
    tick();
    regRead = 1'b1;
    regIndex = idx;
    tick();
    regRead = 1'b0;
    chk({31'h0, regReadValid_reg}, 32'h1);
    chk(regReadData_reg, exp);
  endtask : rd

  // 0 vsync, 1 swap done, 2 retrace end, 3 strip begin, 4 triangle, 5 culled, 6 no-op
  task automatic strobe(input int k);
    tick();
    case (k)
      0: vsyncPulse = 1'b1;
      1: swapDone = 1'b1;
      2: retraceEnd = 1'b1;
      3: triBegin = 1'b1;
      4: triProcessed = 1'b1;
      5: {triProcessed, triCulled} = 2'b11;
      default: nopWrite = 1'b1;
    endcase
    tick();
    {vsyncPulse, swapDone, retraceEnd, triBegin, triProcessed, triCulled, nopWrite} = 7'h00;
  endtask : strobe

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // tests
  initial
  begin
    error_cnt = 0;
    n_compared = 0;
    reset_n = 1'b0;
    {regWrite, regRead, regQueued, nopWrite, swapDone, vsyncPulse, retraceEnd} = 7'h00;
    {triBegin, triProcessed, triCulled, pixValid} = 4'h0;
    regIndex = 4'h0;
    regWriteData = 32'h0000_0000;
    nopWriteData = 32'h0000_0000;
    primaryClipHorizontal = 32'h0000_0fff;
    primaryClipVertical = 32'h0fff_0000;
    pixX = 12'h000;
    pixY = 12'h000;
    repeat (16) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (3) tick();
    for (int i = 0; i < 10; i++) rd(i[3:0], 32'h0000_0000);
    done("reset");
    foreach (cnt[i]) wr(4'h8, 32'hffff_ffff);
    wr(IDX_SWAP_HISTORY, 32'hffff_ffff);
    wr(IDX_TRI_COUNT, 32'hffff_ffff);
    wr(IDX_CLIP_HORIZONTAL, 32'hfffe_0fff);
    wr(IDX_CLIP_VERTICAL, 32'hffff_0ffe);
    wr(IDX_OVERLAY_LEFT, 32'hffff_fff8);
    wr(IDX_OVERLAY_RIGHT, 32'hffff_fff8);
    wr(IDX_SETUP_CONTROL, 32'hffff_ffff);
    rd(4'h8, 32'h0000_0000);
    rd(IDX_SWAP_HISTORY, 32'h0000_0000);
    rd(IDX_TRI_COUNT, 32'h0000_0000);
    rd(IDX_CLIP_HORIZONTAL, 32'h8ffe_0fff);
    rd(IDX_CLIP_VERTICAL, 32'h8fff_0ffe);
    rd(IDX_OVERLAY_LEFT, 32'h80ff_fff8);
    rd(IDX_OVERLAY_RIGHT, 32'h00ff_fff8);
    rd(IDX_SETUP_CONTROL, 32'h000f_00ff);
    chk({22'h0, setupParamEnable, setupFanMode, setupCullEnable}, 32'h3ff);
    done("readback");
    chk({7'h0, overlayLeftEven_reg, overlayLeftAddr_reg}, 32'h0);
    strobe(2);
    chk({7'h0, overlayLeftEven_reg, overlayLeftAddr_reg}, 32'h01ff_fff8);
    chk({8'h0, overlayRightAddr_reg}, 32'h00ff_fff8);
    wr(IDX_OVERLAY_LEFT, 32'h0000_1230);
    chk({8'h0, overlayLeftAddr_reg}, 32'h00ff_fff8);
    strobe(2);
    chk({7'h0, overlayLeftEven_reg, overlayLeftAddr_reg}, 32'h0000_1230);
    done("overlay");
    wr(IDX_SWAP_PENDING, 32'h0000_0000);
    chk({31'h0, swapPendingIncrement_reg}, 32'h1);
    tick();
    chk({31'h0, swapPendingIncrement_reg}, 32'h0);
    regQueued = 1'b1;
    wr(IDX_SWAP_PENDING, 32'hffff_ffff);
    chk({31'h0, swapPendingIncrement_reg}, 32'h0);
    regQueued = 1'b0;
    rd(IDX_SWAP_PENDING, 32'h0000_0000);
    done("swap pending");
    cnt = '{3, 15, 16, 0};
    hist = 32'h0000_0000;
    foreach (cnt[i])
    begin
      repeat (cnt[i]) strobe(0);
      strobe(1);
      hist = {hist[27:0], (cnt[i] > 15) ? 4'hf : cnt[i][3:0]};
      rd(IDX_SWAP_HISTORY, hist);
    end
    done("swap history");
    wr(IDX_SETUP_CONTROL, 32'h0004_0000);
    strobe(3);
    chk({31'h0, setupCullSign}, 32'h1);
    strobe(4);
    chk({31'h0, setupCullSign}, 32'h0);
    wr(IDX_SETUP_CONTROL, 32'h000c_0000);
    chk({31'h0, setupCullSign}, 32'h1);
    wr(IDX_SETUP_CONTROL, 32'h0001_0000);
    chk({30'h0, setupFanMode, setupCullSign}, 32'h2);
    done("setup");
    nopWriteData = 32'h0000_0001;
    strobe(6);
    rd(IDX_TRI_COUNT, 32'h0000_0001);
    nopWriteData = 32'h0000_0002;
    strobe(6);
    rd(IDX_TRI_COUNT, 32'h0000_0000);
    strobe(4);
    strobe(5);
    strobe(4);
    strobe(4);
    rd(IDX_TRI_COUNT, 32'h0000_0003);
    done("triangle count");
    px = '{12'h010, 12'h020, 12'h01f, 12'h010, 12'h00f};
    py = '{12'h005, 12'h005, 12'h007, 12'h008, 12'h005};
    wr(IDX_CLIP_HORIZONTAL, 32'h0010_0020);
    for (int m = 0; m < 3; m++)
    begin
      if (m == 1) wr(IDX_CLIP_HORIZONTAL, 32'h8010_0020);
      wr(IDX_CLIP_VERTICAL, (m == 2) ? 32'h8008_0005 : 32'h0008_0005);
      foreach (px[i])
      begin
        inRect = px[i] >= 12'h010 && px[i] < 12'h020 && py[i] >= 12'h005 && py[i] < 12'h008;
        tick();
        {pixValid, pixX, pixY} = {1'b1, px[i], py[i]};
        tick();
        pixValid = 1'b0;
        chk({31'h0, pixColorWrite}, (m == 0) ? 32'h1 : {31'h0, inRect ^ (m == 2)});
        chk({31'h0, pixAuxWrite}, (m == 0) ? 32'h1 : {31'h0, inRect ^ (m == 2)});
      end
    end
    done("clip");
    report_and_stop();
  end

endmodule : tb_rcs_render_regs
